// ### design/hdle_pkg.sv
// Package for the HDLC descriptor list engine
package hdle_pkg;
  // Register offsets (word index == byte address / 4)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX_HEAD = 8'h04;
  localparam logic [7:0] REG_RX_HEAD = 8'h08;
  localparam logic [7:0] REG_TX_CUR = 8'h0c;
  localparam logic [7:0] REG_RX_CUR = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_TX_FILL = 8'h18;
  localparam logic [7:0] REG_GROUP_BASE = 8'h1c;
  // Control register fields
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_TRANSPARENT = 2;
  localparam int CTRL_WB_INHIBIT = 3;
  localparam int CTRL_TX_ACT = 8;
  localparam int CTRL_RX_ACT = 9;
  // Buffer descriptor fields
  localparam int BD_OWNER = 31;
  localparam int BD_NO_POLL = 30;
  localparam int BD_MSG_END = 29;
  localparam int BD_END_IRQ = 28;
  localparam int BD_IDLE_HI = 26;
  localparam int BD_IDLE_LO = 25;
  localparam int BD_FILL_EN = 24;
  localparam int BD_PAD_HI = 23;
  localparam int BD_PAD_LO = 16;
  localparam int BD_REPEAT = 15;
  localparam int BD_LEN_HI = 13;
  // Message descriptor word offsets and fixed current-pointer slots
  localparam logic [31:0] MD_DATA_OFS = 32'h0000_0004;
  localparam logic [31:0] MD_NEXT_OFS = 32'h0000_0008;
  localparam logic [31:0] CUR_TX_OFS = 32'h0000_0000;
  localparam logic [31:0] CUR_RX_OFS = 32'h0000_0004;
  // Fill octets
  localparam logic [7:0] FILL_FLAG = 8'h7e;
  localparam logic [7:0] FILL_ONES = 8'hff;
  localparam logic [7:0] FILL_ZERO = 8'h00;
  // Timing: poll interval and status write-back delay
  localparam int CLK_HZ = 25000000;
  localparam int POLL_US = 100;
  localparam int POLL_CYC = POLL_US * (CLK_HZ / 1000000);
  localparam int WB_FRAMES = 2;
  localparam int FRAME_US = 125;
  localparam int FRAME_CYC = FRAME_US * (CLK_HZ / 1000000);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RD_BD = 4'h1, ST_WAIT_BD = 4'h2,
    ST_RD_DATA = 4'h3, ST_WAIT_DATA = 4'h4, ST_RD_NEXT = 4'h5,
    ST_WAIT_NEXT = 4'h6, ST_XFER = 4'h7, ST_WR_STAT = 4'h8,
    ST_WR_CUR = 4'h9, ST_POLL = 4'ha, ST_STOP = 4'hb, ST_WB_WAIT = 4'hc
  } hdle_state_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hdle_mreq_t;
  typedef struct packed {
    logic [1:0] idle_fill_select;
    logic fill_insert_enable;
    logic [7:0] fill_octet_minimum;
    logic repeat_en;
    logic message_end_flag;
  } hdle_txfill_t;
endpackage : hdle_pkg

// ### design/hdle_engine.sv
// HDLC descriptor list engine, one channel, transmit and receive lists
`timescale 1ns/1ps
// Summary of operation
// - Status write-back may lag event by two frames
// - List start is pointer 31:2 plus 00b
// - New list start restarts channel processing
// - Host may switch lists via new start
// - Current pointer kept at fixed base offset
// - Current pointer addresses buffer descriptor word
// - First word holds custody, poll, irq, length
// - Custody polarity decoded per direction
// - Transmit custody 1 means device owns buffer
// - Transparent transmit deactivates on host buffer
// - Poll periodically unless no-poll, then wait
// - Message end bit closes frame after buffer
// - End irq bit enables buffer end event
// - Idle fill select picks 7e, ff, 00
// - Fill fields honoured only with message end
// - No fill: single shared flag between messages
// - Fill enable: minimum fill octets from count
// - No indication of extra fill octets
// - Status word overwrites first descriptor word
// - Bits 13:0 give octets to transmit
// - Bit 15 enables repeated transmission
// - Receive custody 1 means host holds buffer
module hdle_engine
  import hdle_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Shared memory master
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  // Serial datapath side
  output logic [1:0] XFER_START,
  output logic [13:0] XFER_LEN,
  output logic [31:0] XFER_DATA_PTR,
  output hdle_txfill_t TX_FILL,
  input wire logic [1:0] XFER_DONE,
  input wire logic [13:0] XFER_COUNT,
  input wire logic FRAME_TICK,
  // Events
  output logic [1:0] BUFFER_END_EVENT,
  output logic [1:0] NO_BUFFER_EVENT
);
  logic [31:0] ctrl;
  logic [31:0] group_base;
  logic [31:0] head [2];
  logic [31:0] cur [2];
  logic [1:0] head_new;
  logic [31:0] bd;
  logic [31:0] data_ptr;
  logic [31:0] next_ptr;
  logic [13:0] done_count;
  logic dir;
  hdle_state_t state;
  logic [15:0] poll_cnt;
  logic [1:0] frames;
  logic [1:0] waiting;
  logic [1:0] active;
  logic [1:0] dev_owns;
  hdle_mreq_t mreq;
  logic [1:0] act_req;
  logic [1:0] stopped;
  logic [31:0] next_cur;

  assign act_req = {REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_RX_ACT],
    REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_TX_ACT]};

  // Register writes; new start pointers are forced word aligned
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl <= 32'h0;
      group_base <= 32'h0;
      head[0] <= 32'h0;
      head[1] <= 32'h0;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        REG_CTRL: ctrl <= {24'h0, REG_WDATA[7:0]};
        REG_TX_HEAD: head[0] <= {REG_WDATA[31:2], 2'b00};
        REG_RX_HEAD: head[1] <= {REG_WDATA[31:2], 2'b00};
        REG_GROUP_BASE: group_base <= {REG_WDATA[31:2], 2'b00};
        default: ;
      endcase
    end
  end

  // Pending list switch per direction, taken at the next buffer boundary
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      head_new <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (REG_WR && REG_ADDR == (i == 0 ? REG_TX_HEAD : REG_RX_HEAD))
          head_new[i] <= 1'b1;
        else if (state == ST_RD_BD && dir == i[0])
          head_new[i] <= 1'b0;
      end
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        REG_CTRL: REG_RDATA <= ctrl;
        REG_TX_HEAD: REG_RDATA <= head[0];
        REG_RX_HEAD: REG_RDATA <= head[1];
        REG_TX_CUR: REG_RDATA <= cur[0];
        REG_RX_CUR: REG_RDATA <= cur[1];
        REG_STATUS: REG_RDATA <= {22'h0, stopped, waiting, active,
          state};
        REG_TX_FILL: REG_RDATA <= {19'h0, TX_FILL};
        REG_GROUP_BASE: REG_RDATA <= group_base;
        default: REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

  // Custody sense differs by direction
  assign dev_owns[0] = MEM_RDATA[BD_OWNER];
  assign dev_owns[1] = !MEM_RDATA[BD_OWNER];
  assign active = {ctrl[CTRL_RX_EN], ctrl[CTRL_TX_EN]};

  // Per-direction wait and stop flags
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      waiting <= 2'b00;
      stopped <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (act_req[i] || head_new[i]) begin
          waiting[i] <= 1'b0;
          stopped[i] <= 1'b0;
        end else if (state == ST_WAIT_BD && MEM_ACK && dir == i[0] &&
            !dev_owns[i]) begin
          if (i == 0 && ctrl[CTRL_TRANSPARENT])
            stopped[i] <= 1'b1;
          else if (MEM_RDATA[BD_NO_POLL])
            waiting[i] <= 1'b1;
        end
      end
    end
  end

  // Memory request drive
  always_comb begin
    mreq = '0;
    unique case (state)
      // Request held through the wait state until acknowledged
      ST_RD_BD: mreq = '{1'b1, 1'b0, head_new[dir] ? head[dir] : cur[dir],
        32'h0};
      ST_WAIT_BD: mreq = '{1'b1, 1'b0, cur[dir], 32'h0};
      ST_RD_DATA, ST_WAIT_DATA:
        mreq = '{1'b1, 1'b0, cur[dir] + MD_DATA_OFS, 32'h0};
      ST_RD_NEXT, ST_WAIT_NEXT:
        mreq = '{1'b1, 1'b0, cur[dir] + MD_NEXT_OFS, 32'h0};
      // Status word returns custody, keeps transmit message end, writes transferred count
      ST_WR_STAT: mreq = '{1'b1, 1'b1, cur[dir],
        {dir, 1'b0, bd[BD_MSG_END] & !dir, 15'h0, done_count}};
      // Mirror names the descriptor serviced next
      ST_WR_CUR: mreq = '{1'b1, 1'b1,
        group_base + (dir ? CUR_RX_OFS : CUR_TX_OFS), next_cur};
      default: mreq = '0;
    endcase
  end
  assign MEM_REQ = mreq.req;
  assign MEM_WE = mreq.we;
  assign MEM_ADDR = mreq.addr;
  assign MEM_WDATA = mreq.wdata;
  // Repeat keeps the same descriptor; only with message end
  assign next_cur = (!dir && bd[BD_MSG_END] && bd[BD_REPEAT]) ? cur[dir] :
    next_ptr;

  // Descriptor walk shared between directions
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_IDLE;
      dir <= 1'b0;
      bd <= 32'h0;
      data_ptr <= 32'h0;
      next_ptr <= 32'h0;
      done_count <= 14'h0;
      poll_cnt <= 16'h0;
      frames <= 2'h0;
      cur[0] <= 32'h0;
      cur[1] <= 32'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Alternate directions so neither list starves
          if (active[!dir] && !waiting[!dir] && !stopped[!dir]) begin
            dir <= !dir;
            state <= ST_RD_BD;
          end else if (active[dir] && !waiting[dir] && !stopped[dir])
            state <= ST_RD_BD;
        end
        ST_RD_BD: begin
          if (head_new[dir])
            cur[dir] <= head[dir];
          state <= ST_WAIT_BD;
        end
        ST_WAIT_BD: if (MEM_ACK) begin
          bd <= MEM_RDATA;
          if (dev_owns[dir])
            state <= ST_RD_DATA;
          else if (!MEM_RDATA[BD_NO_POLL] &&
              !(dir == 1'b0 && ctrl[CTRL_TRANSPARENT])) begin
            poll_cnt <= 16'(POLL_CYC);
            state <= ST_POLL;
          end else
            state <= ST_IDLE;
        end
        ST_POLL: begin
          if (head_new[dir] || act_req[dir])
            state <= ST_RD_BD;
          // Leave room for the other list; a disabled list stops polling
          else if (!active[dir] ||
              (active[!dir] && !waiting[!dir] && !stopped[!dir]))
            state <= ST_IDLE;
          else if (poll_cnt == 16'h0)
            state <= ST_RD_BD;
          else
            poll_cnt <= poll_cnt - 16'h1;
        end
        ST_RD_DATA: state <= ST_WAIT_DATA;
        ST_WAIT_DATA: if (MEM_ACK) begin
          data_ptr <= MEM_RDATA;
          state <= ST_RD_NEXT;
        end
        ST_RD_NEXT: state <= ST_WAIT_NEXT;
        ST_WAIT_NEXT: if (MEM_ACK) begin
          next_ptr <= {MEM_RDATA[31:2], 2'b00};
          state <= ST_XFER;
        end
        ST_XFER: if (XFER_DONE[dir]) begin
          done_count <= XFER_COUNT;
          frames <= 2'h0;
          state <= ctrl[CTRL_WB_INHIBIT] ? ST_WR_CUR : ST_WB_WAIT;
        end
        // Write-back held within two frames of the buffer end event
        ST_WB_WAIT: begin
          if (frames == 2'(WB_FRAMES) - 2'h1 || !FRAME_TICK)
            state <= ST_WR_STAT;
          else
            frames <= frames + 2'h1;
        end
        ST_WR_STAT: if (MEM_ACK) state <= ST_WR_CUR;
        ST_WR_CUR: if (MEM_ACK) begin
          cur[dir] <= next_cur;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Transfer start and buffer end event pulses
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      XFER_START <= 2'b00;
      XFER_LEN <= 14'h0;
      XFER_DATA_PTR <= 32'h0;
      BUFFER_END_EVENT <= 2'b00;
      NO_BUFFER_EVENT <= 2'b00;
    end else begin
      XFER_START <= 2'b00;
      BUFFER_END_EVENT <= 2'b00;
      NO_BUFFER_EVENT <= 2'b00;
      if (state == ST_WAIT_NEXT && MEM_ACK) begin
        XFER_START[dir] <= 1'b1;
        XFER_LEN <= bd[BD_LEN_HI:0];
        XFER_DATA_PTR <= data_ptr;
      end
      if (state == ST_XFER && XFER_DONE[dir])
        BUFFER_END_EVENT[dir] <= bd[BD_END_IRQ];
      if (state == ST_WAIT_BD && MEM_ACK && !dev_owns[dir])
        NO_BUFFER_EVENT[dir] <= 1'b1;
    end
  end

  // Fill fields latched from a message-ending transmit descriptor, cleared for other transmit descriptors
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      TX_FILL <= '0;
    end else if (state == ST_WAIT_DATA && dir == 1'b0) begin
      TX_FILL.message_end_flag <= bd[BD_MSG_END];
      if (bd[BD_MSG_END]) begin
        TX_FILL.idle_fill_select <= bd[BD_IDLE_HI:BD_IDLE_LO];
        TX_FILL.fill_insert_enable <= bd[BD_FILL_EN];
        TX_FILL.fill_octet_minimum <= bd[BD_PAD_HI:BD_PAD_LO];
        TX_FILL.repeat_en <= bd[BD_REPEAT];
      end else begin
        TX_FILL.idle_fill_select <= 2'b00;
        TX_FILL.fill_insert_enable <= 1'b0;
        TX_FILL.fill_octet_minimum <= 8'h0;
        TX_FILL.repeat_en <= 1'b0;
      end
    end
  end
  // Extra fill beyond the minimum is not reported anywhere
endmodule : hdle_engine

// ### dv/hdle_engine_properties.sv
// Port assertions for the descriptor list engine
`timescale 1ns/1ps
module hdle_engine_props
  import hdle_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Memory master
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  // Datapath side
  input wire logic [1:0] XFER_START,
  input wire logic [13:0] XFER_LEN,
  input wire logic [31:0] XFER_DATA_PTR,
  input wire hdle_txfill_t TX_FILL,
  input wire logic [1:0] XFER_DONE,
  input wire logic [1:0] BUFFER_END_EVENT
);
  // Word0, data pointer, next pointer; assumes tx and rx do not interleave
  logic [2:0][31:0] rd;
  logic irq_on;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd <= '0;
    end else if (MEM_ACK && !MEM_WE) begin
      rd <= {rd[1:0], MEM_RDATA};
    end
  end
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_on <= 1'b0;
    end else if (XFER_START[0]) begin
      irq_on <= rd[2][BD_END_IRQ];
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  property p_align; MEM_REQ |-> MEM_ADDR[1:0] == 2'b00; endproperty
  a_align: assert property (p_align) else $error("unaligned");
  property p_hold; MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR);
  endproperty
  a_hold: assert property (p_hold) else $error("req dropped");
  property p_tx_start; XFER_START[0] |-> rd[2][BD_OWNER] &&
    XFER_LEN == rd[2][13:0] && XFER_DATA_PTR == rd[1]; endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start");
  property p_rx_start; XFER_START[1] |-> !rd[2][BD_OWNER] &&
    XFER_LEN == rd[2][13:0]; endproperty
  a_rx_start: assert property (p_rx_start) else $error("rx start");
  property p_fill_end; XFER_START[0] |-> TX_FILL.message_end_flag ==
    rd[2][BD_MSG_END] && (rd[2][BD_MSG_END] ||
    (!TX_FILL.fill_insert_enable && !TX_FILL.repeat_en)); endproperty
  a_fill_end: assert property (p_fill_end) else $error("fill gate");
  property p_fill_val; XFER_START[0] && rd[2][BD_MSG_END] |->
    TX_FILL.idle_fill_select == rd[2][26:25] &&
    TX_FILL.fill_insert_enable == rd[2][24] &&
    TX_FILL.repeat_en == rd[2][15] &&
    (!rd[2][24] || TX_FILL.fill_octet_minimum == rd[2][23:16]); endproperty
  a_fill_val: assert property (p_fill_val) else $error("fill value");
  property p_irq_gate; BUFFER_END_EVENT[0] |-> irq_on; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("end event");
  property p_irq_fire; XFER_DONE[0] && irq_on |-> ##[0:4] BUFFER_END_EVENT[0];
  endproperty
  a_irq_fire: assert property (p_irq_fire) else $error("no end event");
endmodule : hdle_engine_props

// ### dv/hdle_mem_model.sv
// Shared memory model standing in for host memory
`timescale 1ns/1ps
module hdle_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request side
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic slow,
  // Answer side
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:255];
  logic [2:0] dly;
  // Idle read data toggles so a stale word never passes for a fresh one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      dly <= 3'h0;
      rdata <= 32'h0;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack && dly < {slow, 2'b00}) begin
        dly <= dly + 3'h1;
      end else if (req && !ack) begin
        ack <= 1'b1;
        dly <= 3'h0;
        if (we) begin
          mem[addr[9:2]] <= wdata;
        end else begin
          rdata <= mem[addr[9:2]];
        end
      end
    end
  end
endmodule : hdle_mem_model

// ### dv/hdle_engine_bench.sv
// Self-checking bench for the descriptor list engine
`timescale 1ns/1ps
module hdle_engine_bench
  import hdle_pkg::*;
;
  logic SYS_CLK = 1'b0, RESETN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [31:0] XFER_DATA_PTR;
  logic MEM_REQ, MEM_WE, MEM_ACK, FRAME_TICK = 1'b0, slow = 1'b0;
  logic [1:0] XFER_START, XFER_DONE = 2'b00, BUFFER_END_EVENT, NO_BUFFER_EVENT;
  logic [13:0] XFER_LEN, XFER_COUNT = 14'h0;
  hdle_txfill_t TX_FILL;
  logic [4:0] ev;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  assign ev = {NO_BUFFER_EVENT, BUFFER_END_EVENT[0], XFER_START};
  always #20 SYS_CLK = ~SYS_CLK;
  hdle_engine u_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .XFER_START(XFER_START), .XFER_LEN(XFER_LEN),
    .XFER_DATA_PTR(XFER_DATA_PTR), .TX_FILL(TX_FILL), .XFER_DONE(XFER_DONE),
    .XFER_COUNT(XFER_COUNT), .FRAME_TICK(FRAME_TICK),
    .BUFFER_END_EVENT(BUFFER_END_EVENT), .NO_BUFFER_EVENT(NO_BUFFER_EVENT));
  hdle_mem_model u_mem (.clk(SYS_CLK), .rst_n(RESETN), .req(MEM_REQ),
    .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA), .slow(slow),
    .ack(MEM_ACK), .rdata(MEM_RDATA));
  // Frame tick every 64 cycles; run limit well above the longest poll
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    FRAME_TICK <= (cyc[5:0] == 6'h3f);
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task wrap_up;
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task check(input string n, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, exp, seen);
    end
  endtask : check
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1;
    check("reg read", REG_RDATA, exp);
  endtask : reg_rd
  task wait_ev(input string n, input int i, lim, input logic exp);
    logic hit;
    hit = 1'b0;
    // Current cycle first, so a pulse launched on return is not missed
    #1;
    repeat (lim) begin
      if (ev[i] === 1'b1) begin
        hit = 1'b1;
        break;
      end
      @(posedge SYS_CLK);
      #1;
    end
    check(n, {31'h0, hit}, {31'h0, exp});
  endtask : wait_ev
  task wait_own(input string n, input int i, input logic own,
    input logic [31:0] exp);
    repeat (400) begin
      if (u_mem.mem[i][31] === own) break;
      @(posedge SYS_CLK);
      #1;
    end
    check(n, u_mem.mem[i], exp);
  endtask : wait_own
  task put3(input int i, input logic [31:0] w, d, n);
    u_mem.mem[i] = w;
    u_mem.mem[i+1] = d;
    u_mem.mem[i+2] = n;
  endtask : put3
  task done(input int i, input logic [13:0] n);
    @(posedge SYS_CLK);
    XFER_DONE[i] <= 1'b1;
    XFER_COUNT <= n;
    @(posedge SYS_CLK);
    XFER_DONE <= 2'b00;
  endtask : done
  task s_tx_list;
    slow = 1'b1;
    put3(8'h40, 32'hb302_0005, 32'h180, 32'h110);
    put3(8'h44, 32'h8507_8003, 32'h184, 32'h120);
    put3(8'h48, 32'h4000_0004, 32'h18c, 32'h130);
    put3(8'h4c, 32'h0000_0006, 32'h190, 32'h140);
    u_mem.mem[8'h50] = 32'h4000_0001;
    reg_wr(REG_GROUP_BASE, 32'h200);
    reg_wr(REG_TX_HEAD, 32'h103);
    reg_wr(REG_CTRL, 32'h1);
    wait_ev("tx start", 0, 300, 1'b1);
    check("tx len", 32'(XFER_LEN), 32'h5);
    check("tx ptr", XFER_DATA_PTR, 32'h180);
    check("tx fill", 32'(TX_FILL), 32'hc09);
    done(0, 14'd5);
    wait_ev("end event", 2, 8, 1'b1);
    wait_own("tx status", 8'h40, 1'b0, 32'h2000_0005);
    slow = 1'b0;
    wait_ev("tx start", 0, 300, 1'b1);
    check("tx cur", u_mem.mem[8'h80], 32'h110);
    check("part fill", {29'h0, TX_FILL.fill_insert_enable, TX_FILL.repeat_en,
      TX_FILL.message_end_flag}, 32'h0);
    done(0, 14'd3);
    wait_ev("no end event", 2, 8, 1'b0);
    wait_own("tx status", 8'h44, 1'b0, 32'h0000_0003);
    wait_ev("no buffer", 3, 300, 1'b1);
  endtask : s_tx_list
  task s_poll;
    u_mem.mem[8'h48][31] = 1'b1;
    wait_ev("no poll", 0, 3000, 1'b0);
    reg_wr(REG_CTRL, 32'h101);
    wait_ev("activate", 0, 200, 1'b1);
    done(0, 14'd4);
    wait_ev("host held", 0, 1000, 1'b0);
    u_mem.mem[8'h4c][31] = 1'b1;
    wait_ev("poll", 0, POLL_CYC + 300, 1'b1);
    done(0, 14'd6);
    wait_ev("no buffer", 3, 400, 1'b1);
    // Second list built while the channel waits on the first
    put3(8'h54, 32'hb000_0002, 32'h188, 32'h140);
    reg_wr(REG_TX_HEAD, 32'h150);
    wait_ev("new list", 0, 300, 1'b1);
    check("new len", 32'(XFER_LEN), 32'h2);
    done(0, 14'd2);
  endtask : s_poll
  task s_rx;
    put3(8'h58, 32'h0000_0009, 32'h194, 32'h170);
    u_mem.mem[8'h5c] = 32'h8000_0008;
    reg_wr(REG_RX_HEAD, 32'h160);
    reg_wr(REG_CTRL, 32'h3);
    wait_ev("rx start", 1, 300, 1'b1);
    check("rx len", 32'(XFER_LEN), 32'h9);
    done(1, 14'd7);
    wait_own("rx status", 8'h58, 1'b1, 32'h8000_0007);
    wait_ev("rx no buffer", 4, 400, 1'b1);
    check("rx cur", u_mem.mem[8'h81], 32'h170);
    check("tx cur", u_mem.mem[8'h80], 32'h140);
    reg_rd(REG_RX_CUR, 32'h170);
    reg_rd(8'hfc, 32'h0);
  endtask : s_rx
  task s_modes;
    // Transparent transmit, write-back inhibited, receive switched off
    put3(8'h60, 32'hb5ff_0001, 32'h198, 32'h190);
    u_mem.mem[8'h64] = 32'h0000_0000;
    reg_wr(REG_CTRL, 32'hd);
    reg_wr(REG_TX_HEAD, 32'h180);
    wait_ev("tr start", 0, 300, 1'b1);
    done(0, 14'd1);
    wait_ev("tr stop", 3, 300, 1'b1);
    check("inhibit", u_mem.mem[8'h60], 32'hb5ff_0001);
    check("tr cur", u_mem.mem[8'h80], 32'h190);
    reg_rd(REG_STATUS, 32'h110);
    reg_rd(REG_TX_FILL, 32'h17fd);
  endtask : s_modes
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    s_tx_list();
    s_poll();
    s_rx();
    s_modes();
    wrap_up();
  end
endmodule : hdle_engine_bench
bind hdle_engine hdle_engine_props u_props (.SYS_CLK(SYS_CLK),
  .RESETN(RESETN), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
  .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .XFER_START(XFER_START),
  .XFER_LEN(XFER_LEN), .XFER_DATA_PTR(XFER_DATA_PTR), .TX_FILL(TX_FILL),
  .XFER_DONE(XFER_DONE), .BUFFER_END_EVENT(BUFFER_END_EVENT));
